// File: rtl/wwd_map.vh
// Constants for the windowed watchdog pair: option word layout,
// divider and timeout selections, window position codes.
// Assumes inclusion by bare name from the design file.
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// Boot option word, main dog fields (LSB positions)
`define WWD_OPT_M_AUTO      0
`define WWD_OPT_M_CKS       1
`define WWD_OPT_M_TOPS      4
`define WWD_OPT_M_WST       6
`define WWD_OPT_M_WEND      8
`define WWD_OPT_M_RST       10
`define WWD_OPT_M_NMI       11
// Boot option word, independent dog fields (LSB positions)
`define WWD_OPT_I_AUTO      16
`define WWD_OPT_I_CKS       17
`define WWD_OPT_I_TOPS      20
`define WWD_OPT_I_WST       22
`define WWD_OPT_I_WEND      24
`define WWD_OPT_I_RST       26
`define WWD_OPT_I_NMI       27
`define WWD_OPT_I_STOP      28
`define WWD_OPT_WIDTH       32

// Main refresh key pair
`define WWD_KEY_ARM         8'h00
`define WWD_KEY_FIRE        8'hff

// Timeout select: counter reload values (cycles - 1)
`define WWD_TOP_0           14'h03ff
`define WWD_TOP_1           14'h0fff
`define WWD_TOP_2           14'h1fff
`define WWD_TOP_3           14'h3fff

// Main dog divider ratios minus one, select codes 0..5
`define WWD_MDIV_0          13'h0003
`define WWD_MDIV_1          13'h003f
`define WWD_MDIV_2          13'h007f
`define WWD_MDIV_3          13'h01ff
`define WWD_MDIV_4          13'h07ff
`define WWD_MDIV_5          13'h1fff
// Independent dog divider ratios minus one, select codes 0..5
`define WWD_IDIV_0          13'h0000
`define WWD_IDIV_1          13'h000f
`define WWD_IDIV_2          13'h001f
`define WWD_IDIV_3          13'h003f
`define WWD_IDIV_4          13'h007f
`define WWD_IDIV_5          13'h00ff

// Window start codes: 0=100% 1=75% 2=50% 3=25%; end codes: 0=75% 1=50% 2=25% 3=0%
`define WWD_WIN_CODE_W      2

`endif

// File: rtl/wwd_pair.v
// Windowed watchdog pair: main dog on clk_i, independent dog on a
// sampled dedicated clock pin, both with prescaler and 14-bit down-counter.
// Assumes CPU writes arrive as one-cycle strobes on clk_i and that the
// boot option word is stable across reset release.
//
// Summary of operation
// - Main dog prescaler divides clock by 4, 64, 128, 512, 2048 or 8192.
// - Independent dog prescaler divides its clock by 1, 16, 32, 64, 128 or 256.
// - Auto-start mode begins counting at reset release using boot option settings.
// - Register start mode: software programs controls, first refresh starts counting.
// - Main refresh is write 00h then FFh to its refresh register.
// - Independent dog refreshed by a write inside its permitted window.
// - Register start mode reloads counter from control timeout select.
// - Auto-start mode reloads counter from option timeout select.
// - Auto-start mode takes divider, window, timeout and action from option word.
// - Counting stops on underflow or refresh error; reset restores initial values.
// - Underflow gives internal reset if permitted, else an interrupt request.
// - Each dog's interrupt goes out as non-maskable or maskable.
// - Register start mode: control registers accept one write before first refresh, later ones ignored.
// - Stop-all halts main dog, keeping counter and state.
`timescale 1ns/100ps
`include "wwd_map.vh"

module wwd_dog #(
   parameter IS_MAIN = 1
) (
   input  wire        clk_i,       // System clock
   input  wire        reset_i,     // Async reset, active high
   input  wire        tick_i,      // Base count enable
   input  wire        halt_i,      // Freeze counting
   input  wire        boot_i,      // Option word valid
   input  wire        start_i,     // One-cycle pulse at boot load
   input  wire        refr_ok_i,   // Valid refresh pulse
   input  wire        refr_bad_i,  // Bad sequence pulse
   input  wire        cwr_i,       // Control write strobe
   input  wire [2:0]  c_cks_i,     // Control divider select
   input  wire [1:0]  c_tops_i,    // Control timeout select
   input  wire [1:0]  c_wst_i,     // Control window start
   input  wire [1:0]  c_wend_i,    // Control window end
   input  wire        rwr_i,       // Reset-control write strobe
   input  wire        r_rst_i,     // Reset output permitted
   input  wire        r_nmi_i,     // Interrupt as NMI
   input  wire        o_auto_i,    // Option auto-start
   input  wire [2:0]  o_cks_i,     // Option divider select
   input  wire [1:0]  o_tops_i,    // Option timeout select
   input  wire [1:0]  o_wst_i,     // Option window start
   input  wire [1:0]  o_wend_i,    // Option window end
   input  wire        o_rst_i,     // Option reset permitted
   input  wire        o_nmi_i,     // Option NMI select
   output reg  [13:0] count_o,     // Down-counter value
   output reg         running_o,   // Counting
   output reg         rst_req_o,   // Reset request pulse
   output reg         nmi_o,       // NMI pulse
   output reg         irq_o,       // Maskable interrupt pulse
   output reg         under_o,     // Sticky underflow seen
   output reg         err_o        // Sticky refresh error seen
);

   reg  [12:0] pre_reg;
   reg  [2:0]  cks_reg;
   reg  [1:0]  tops_reg;
   reg  [1:0]  wst_reg;
   reg  [1:0]  wend_reg;
   reg         rst_reg;
   reg         nmi_reg;
   reg         clock_reg;
   reg         rlock_reg;
   reg         started_reg;

   // divider ratio minus one per select code
   function [12:0] div_lim;
      input       main;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    div_lim = main ? `WWD_MDIV_0 : `WWD_IDIV_0;
            3'h1:    div_lim = main ? `WWD_MDIV_1 : `WWD_IDIV_1;
            3'h2:    div_lim = main ? `WWD_MDIV_2 : `WWD_IDIV_2;
            3'h3:    div_lim = main ? `WWD_MDIV_3 : `WWD_IDIV_3;
            3'h4:    div_lim = main ? `WWD_MDIV_4 : `WWD_IDIV_4;
            default: div_lim = main ? `WWD_MDIV_5 : `WWD_IDIV_5;
         endcase
      end
   endfunction

   function [13:0] top_val;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    top_val = `WWD_TOP_0;
            2'h1:    top_val = `WWD_TOP_1;
            2'h2:    top_val = `WWD_TOP_2;
            default: top_val = `WWD_TOP_3;
         endcase
      end
   endfunction

   // option word overrides registers in auto-start mode
   wire        auto_m = o_auto_i;
   wire [2:0]  e_cks  = auto_m ? o_cks_i  : cks_reg;
   wire [1:0]  e_tops = auto_m ? o_tops_i : tops_reg;
   wire [1:0]  e_wst  = auto_m ? o_wst_i  : wst_reg;
   wire [1:0]  e_wend = auto_m ? o_wend_i : wend_reg;
   wire        e_rst  = auto_m ? o_rst_i  : rst_reg;
   wire        e_nmi  = auto_m ? o_nmi_i  : nmi_reg;

   // reload value follows the active timeout select
   wire [13:0] top    = top_val(e_tops);
   wire [13:0] quart  = top[13:2] + 14'h0001;
   wire [13:0] q2     = {quart[12:0], 1'b0};
   wire [13:0] q3     = quart + q2;
   reg  [13:0] win_hi;
   reg  [13:0] win_lo;

   always @* begin
      case (e_wst)
         2'h0:    win_hi = top;
         2'h1:    win_hi = q3 - 14'h0001;
         2'h2:    win_hi = q2 - 14'h0001;
         default: win_hi = quart - 14'h0001;
      endcase
      case (e_wend)
         2'h0:    win_lo = q3;
         2'h1:    win_lo = q2;
         2'h2:    win_lo = quart;
         default: win_lo = 14'h0000;
      endcase
   end

   wire in_win  = (count_o <= win_hi) && (count_o >= win_lo);
   // halt freezes prescaler and counter in place
   wire pre_en  = tick_i && running_o && !halt_i;
   wire step    = pre_en && (pre_reg >= div_lim(IS_MAIN != 0, e_cks));
   wire undflow = step && (count_o == 14'h0000);
   // window miss or bad pair counts as refresh error
   wire refr_err = running_o && (refr_bad_i || (refr_ok_i && !in_win));
   wire event_hit = undflow || refr_err;
   wire load     = boot_i && ((refr_ok_i && (!running_o || in_win)) || (start_i && auto_m));

   // one write per register, only before first refresh
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cks_reg     <= 3'h0;
         tops_reg    <= 2'h3;
         wst_reg     <= 2'h0;
         wend_reg    <= 2'h3;
         rst_reg     <= 1'b0;
         nmi_reg     <= 1'b0;
         clock_reg   <= 1'b0;
         rlock_reg   <= 1'b0;
         started_reg <= 1'b0;
      end else begin
         if (cwr_i && !clock_reg && !started_reg && !auto_m) begin
            cks_reg   <= c_cks_i;
            tops_reg  <= c_tops_i;
            wst_reg   <= c_wst_i;
            wend_reg  <= c_wend_i;
            clock_reg <= 1'b1;
         end
         if (rwr_i && !rlock_reg && !started_reg && !auto_m) begin
            rst_reg   <= r_rst_i;
            nmi_reg   <= r_nmi_i;
            rlock_reg <= 1'b1;
         end
         if (refr_ok_i)
            started_reg <= 1'b1;
      end
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pre_reg   <= 13'h0000;
         count_o   <= 14'h0000;
         running_o <= 1'b0;
         rst_req_o <= 1'b0;
         nmi_o     <= 1'b0;
         irq_o     <= 1'b0;
         under_o   <= 1'b0;
         err_o     <= 1'b0;
      end else begin
         rst_req_o <= 1'b0;
         nmi_o     <= 1'b0;
         irq_o     <= 1'b0;
         if (event_hit) begin
            // counting stops on underflow or error
            running_o <= 1'b0;
            pre_reg   <= 13'h0000;
            // reset if permitted, else NMI or maskable
            rst_req_o <= e_rst;
            nmi_o     <= !e_rst && e_nmi;
            irq_o     <= !e_rst && !e_nmi;
            under_o   <= under_o | undflow;
            err_o     <= err_o | refr_err;
         end else if (load) begin
            // auto-start at boot, register mode on first refresh
            count_o   <= top;
            pre_reg   <= 13'h0000;
            running_o <= 1'b1;
         end else if (step) begin
            pre_reg <= 13'h0000;
            count_o <= count_o - 14'h0001;
         end else if (pre_en) begin
            pre_reg <= pre_reg + 13'h0001;
         end
      end
   end

endmodule

module wwd_pair (
   input  wire        clk_i,          // Peripheral clock, 20 MHz
   input  wire        reset_i,        // Async reset, active high
   input  wire        ind_clk_i,      // Independent dog clock pin
   input  wire        all_stop_i,     // All modules stopped
   input  wire [31:0] boot_word_i,    // Boot option word
   input  wire        m_refr_wr_i,    // Main refresh register write
   input  wire [7:0]  m_refr_data_i,  // Main refresh write data
   input  wire        i_refr_wr_i,    // Independent refresh register write
   input  wire        m_ctrl_wr_i,    // Main control register write
   input  wire        i_ctrl_wr_i,    // Independent control register write
   input  wire [2:0]  ctrl_cks_i,     // Control divider select
   input  wire [1:0]  ctrl_tops_i,    // Control timeout select
   input  wire [1:0]  ctrl_wst_i,     // Control window start
   input  wire [1:0]  ctrl_wend_i,    // Control window end
   input  wire        m_rctrl_wr_i,   // Main reset-control write
   input  wire        i_rctrl_wr_i,   // Independent reset-control write
   input  wire        rctrl_rst_i,    // Reset output permitted
   input  wire        rctrl_nmi_i,    // Interrupt as NMI
   output reg         int_reset_o,    // Internal reset pulse
   output wire        m_nmi_o,        // Main NMI pulse
   output wire        m_irq_o,        // Main interrupt pulse
   output wire        i_nmi_o,        // Independent NMI pulse
   output wire        i_irq_o,        // Independent interrupt pulse
   output wire [13:0] m_count_o,      // Main counter
   output wire [13:0] i_count_o,      // Independent counter
   output wire        m_running_o,    // Main counting
   output wire        i_running_o,    // Independent counting
   output wire        m_under_o,      // Main underflow seen
   output wire        i_under_o,      // Independent underflow seen
   output wire        m_err_o,        // Main refresh error seen
   output wire        i_err_o         // Independent refresh error seen
);

   reg  [31:0] boot_reg;
   reg         boot_ok_reg;
   reg         start_reg;
   reg         s1_reg;
   reg         s2_reg;
   reg         s3_reg;
   reg         lvl_reg;
   reg         itick_reg;
   reg         armed_reg;
   reg         m_ok_reg;
   reg         m_bad_reg;
   reg         i_ok_reg;
   wire        m_rst;
   wire        i_rst;

   // Strap caught after release, never under reset
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         boot_reg    <= 32'h0000_0000;
         boot_ok_reg <= 1'b0;
         start_reg   <= 1'b0;
      end else begin
         start_reg <= !boot_ok_reg;
         if (!boot_ok_reg) begin
            boot_reg    <= boot_word_i;
            boot_ok_reg <= 1'b1;
         end
      end
   end

   // Pin clock sampled; a rising edge counts when stages two and three agree
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         lvl_reg   <= 1'b0;
         itick_reg <= 1'b0;
      end else begin
         s1_reg    <= ind_clk_i;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         itick_reg <= 1'b0;
         if (s2_reg == s3_reg && s2_reg != lvl_reg) begin
            lvl_reg   <= s2_reg;
            itick_reg <= s2_reg;
         end
      end
   end

   // only 00h followed by FFh refreshes the main dog
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         armed_reg <= 1'b0;
         m_ok_reg  <= 1'b0;
         m_bad_reg <= 1'b0;
         i_ok_reg  <= 1'b0;
      end else begin
         m_ok_reg  <= 1'b0;
         m_bad_reg <= 1'b0;
         i_ok_reg  <= i_refr_wr_i;
         if (m_refr_wr_i) begin
            if (m_refr_data_i == `WWD_KEY_ARM) begin
               armed_reg <= 1'b1;
            end else begin
               armed_reg <= 1'b0;
               m_ok_reg  <= armed_reg && (m_refr_data_i == `WWD_KEY_FIRE);
               m_bad_reg <= !(armed_reg && (m_refr_data_i == `WWD_KEY_FIRE));
            end
         end
      end
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         int_reset_o <= 1'b0;
      else
         int_reset_o <= m_rst | i_rst;
   end

   // main dog on the peripheral clock, window checked inside
   wwd_dog #(.IS_MAIN(1)) u_main (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .tick_i     (1'b1),
      .halt_i     (all_stop_i),
      .boot_i     (boot_ok_reg),
      .start_i    (start_reg),
      .refr_ok_i  (m_ok_reg),
      .refr_bad_i (m_bad_reg),
      .cwr_i      (m_ctrl_wr_i),
      .c_cks_i    (ctrl_cks_i),
      .c_tops_i   (ctrl_tops_i),
      .c_wst_i    (ctrl_wst_i),
      .c_wend_i   (ctrl_wend_i),
      .rwr_i      (m_rctrl_wr_i),
      .r_rst_i    (rctrl_rst_i),
      .r_nmi_i    (rctrl_nmi_i),
      .o_auto_i   (boot_reg[`WWD_OPT_M_AUTO]),
      .o_cks_i    (boot_reg[`WWD_OPT_M_CKS+2:`WWD_OPT_M_CKS]),
      .o_tops_i   (boot_reg[`WWD_OPT_M_TOPS+1:`WWD_OPT_M_TOPS]),
      .o_wst_i    (boot_reg[`WWD_OPT_M_WST+1:`WWD_OPT_M_WST]),
      .o_wend_i   (boot_reg[`WWD_OPT_M_WEND+1:`WWD_OPT_M_WEND]),
      .o_rst_i    (boot_reg[`WWD_OPT_M_RST]),
      .o_nmi_i    (boot_reg[`WWD_OPT_M_NMI]),
      .count_o    (m_count_o),
      .running_o  (m_running_o),
      .rst_req_o  (m_rst),
      .nmi_o      (m_nmi_o),
      .irq_o      (m_irq_o),
      .under_o    (m_under_o),
      .err_o      (m_err_o)
   );

   // independent dog ticks from its own pin clock
   wwd_dog #(.IS_MAIN(0)) u_ind (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .tick_i     (itick_reg),
      .halt_i     (all_stop_i & boot_reg[`WWD_OPT_I_STOP]),
      .boot_i     (boot_ok_reg),
      .start_i    (start_reg),
      .refr_ok_i  (i_ok_reg),
      .refr_bad_i (1'b0),
      .cwr_i      (i_ctrl_wr_i),
      .c_cks_i    (ctrl_cks_i),
      .c_tops_i   (ctrl_tops_i),
      .c_wst_i    (ctrl_wst_i),
      .c_wend_i   (ctrl_wend_i),
      .rwr_i      (i_rctrl_wr_i),
      .r_rst_i    (rctrl_rst_i),
      .r_nmi_i    (rctrl_nmi_i),
      .o_auto_i   (boot_reg[`WWD_OPT_I_AUTO]),
      .o_cks_i    (boot_reg[`WWD_OPT_I_CKS+2:`WWD_OPT_I_CKS]),
      .o_tops_i   (boot_reg[`WWD_OPT_I_TOPS+1:`WWD_OPT_I_TOPS]),
      .o_wst_i    (boot_reg[`WWD_OPT_I_WST+1:`WWD_OPT_I_WST]),
      .o_wend_i   (boot_reg[`WWD_OPT_I_WEND+1:`WWD_OPT_I_WEND]),
      .o_rst_i    (boot_reg[`WWD_OPT_I_RST]),
      .o_nmi_i    (boot_reg[`WWD_OPT_I_NMI]),
      .count_o    (i_count_o),
      .running_o  (i_running_o),
      .rst_req_o  (i_rst),
      .nmi_o      (i_nmi_o),
      .irq_o      (i_irq_o),
      .under_o    (i_under_o),
      .err_o      (i_err_o)
   );

endmodule

// File: bench/wwd_pair_assertions.sv
// Concurrent checks on the top ports of the watchdog pair.
// Assumes a bind onto wwd_pair and the single clk_i domain.
`timescale 1ns/100ps
module wwd_pair_assertions (
   input wire        clk_i,          // Clock
   input wire        reset_i,        // Async reset
   input wire        all_stop_i,     // Stop-all level
   input wire        m_refr_wr_i,    // Main refresh write
   input wire [7:0]  m_refr_data_i,  // Main refresh data
   input wire        int_reset_o,    // Internal reset pulse
   input wire        m_nmi_o,        // Main NMI pulse
   input wire        m_irq_o,        // Main IRQ pulse
   input wire        i_nmi_o,        // Independent NMI pulse
   input wire        i_irq_o,        // Independent IRQ pulse
   input wire [13:0] m_count_o,      // Main counter
   input wire        m_running_o,    // Main counting
   input wire        m_under_o,      // Main underflow flag
   input wire        i_under_o,      // Independent underflow flag
   input wire        m_err_o,        // Main error flag
   input wire        i_err_o         // Independent error flag
);
   reg [1:0] age_reg;
   // Cycles since release, so no past value reaches into reset
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) age_reg <= 2'h0;
      else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_start;
      age_reg == 2'h3 && !all_stop_i && !m_running_o && m_refr_wr_i && m_refr_data_i == 8'hff
      && $past(m_refr_wr_i) && $past(m_refr_data_i) == 8'h00 |-> ##2 m_running_o;
   endproperty
   a_start: assert property (p_start) else $error("main dog not started by key pair");
   property p_under_zero;
      $rose(m_under_o) |-> $past(m_count_o) == 14'h0000 && !m_running_o;
   endproperty
   a_under_zero: assert property (p_under_zero) else $error("underflow not from zero");
   property p_err_stop;
      $rose(m_err_o) |-> !m_running_o && $past(m_running_o);
   endproperty
   a_err_stop: assert property (p_err_stop) else $error("error without stop");
   property p_stop_hold;
      all_stop_i && m_running_o |=> $stable(m_count_o) && m_running_o;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("main dog moved while stopped");
   property p_m_cause;
      m_irq_o || m_nmi_o |-> m_under_o || m_err_o;
   endproperty
   a_m_cause: assert property (p_m_cause) else $error("main event without cause");
   property p_i_cause;
      i_irq_o || i_nmi_o |-> i_under_o || i_err_o;
   endproperty
   a_i_cause: assert property (p_i_cause) else $error("independent event without cause");
   property p_nmi_one;
      m_nmi_o |-> !m_irq_o ##1 !m_nmi_o;
   endproperty
   a_nmi_one: assert property (p_nmi_one) else $error("main nmi not a lone pulse");
   property p_rst_cause;
      int_reset_o |-> (m_under_o || m_err_o || i_under_o || i_err_o) ##1 !int_reset_o;
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("internal reset without cause");
   property p_reset_vals;
      age_reg == 2'h0 |-> m_count_o == 14'h0000 && !m_running_o && !m_under_o && !m_err_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
   c_under: cover property ($rose(m_under_o));
   c_err: cover property ($rose(m_err_o));
   c_rst: cover property (int_reset_o);
   c_stop: cover property (all_stop_i && m_running_o);
endmodule

bind wwd_pair wwd_pair_assertions chk_u (
   .clk_i(clk_i), .reset_i(reset_i), .all_stop_i(all_stop_i), .m_refr_wr_i(m_refr_wr_i),
   .m_refr_data_i(m_refr_data_i), .int_reset_o(int_reset_o), .m_nmi_o(m_nmi_o), .m_irq_o(m_irq_o),
   .i_nmi_o(i_nmi_o), .i_irq_o(i_irq_o), .m_count_o(m_count_o), .m_running_o(m_running_o),
   .m_under_o(m_under_o), .i_under_o(i_under_o), .m_err_o(m_err_o), .i_err_o(i_err_o)
);

// File: bench/wwd_pair_tb.sv
// Self-checking bench for the windowed watchdog pair.
// Assumes the checker binds itself; inputs change on falling clk_i.
`timescale 1ns/100ps
module wwd_pair_tb;
   reg         clk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg         ind_clk_i = 1'b0;
   reg         all_stop_i = 1'b0;
   reg  [31:0] boot_word_i = 32'h0;
   reg         m_refr_wr_i = 1'b0;
   reg  [7:0]  m_refr_data_i = 8'h00;
   reg         i_refr_wr_i = 1'b0;
   reg         m_ctrl_wr_i = 1'b0;
   reg         i_ctrl_wr_i = 1'b0;
   reg  [2:0]  ctrl_cks_i = 3'h0;
   reg  [1:0]  ctrl_tops_i = 2'h0;
   reg  [1:0]  ctrl_wst_i = 2'h0;
   reg  [1:0]  ctrl_wend_i = 2'h3;
   reg         m_rctrl_wr_i = 1'b0;
   reg         i_rctrl_wr_i = 1'b0;
   reg         rctrl_rst_i = 1'b0;
   reg         rctrl_nmi_i = 1'b0;
   wire        int_reset_o, m_nmi_o, m_irq_o, i_nmi_o, i_irq_o;
   wire [13:0] m_count_o, i_count_o;
   wire        m_running_o, i_running_o, m_under_o, i_under_o, m_err_o, i_err_o;
   reg  [4:0]  seen;
   reg  [13:0] snap, snap2;
   reg  [17:0] rows [0:11];
   integer     fails = 0;
   integer     n_compared = 0;
   integer     k, n;

   always #25 clk_i = ~clk_i;
   // Dog clock of 4 clk_i periods, edges away from rising clk_i
   always #100 ind_clk_i = ~ind_clk_i;
   // One-cycle pulses are caught here so no check needs exact timing
   always @(negedge clk_i) begin
      if (reset_i) seen <= 5'h00;
      else seen <= seen | {i_irq_o, i_nmi_o, m_irq_o, m_nmi_o, int_reset_o};
   end

   wwd_pair dut_u (
      .clk_i(clk_i), .reset_i(reset_i), .ind_clk_i(ind_clk_i), .all_stop_i(all_stop_i),
      .boot_word_i(boot_word_i), .m_refr_wr_i(m_refr_wr_i), .m_refr_data_i(m_refr_data_i),
      .i_refr_wr_i(i_refr_wr_i), .m_ctrl_wr_i(m_ctrl_wr_i), .i_ctrl_wr_i(i_ctrl_wr_i),
      .ctrl_cks_i(ctrl_cks_i), .ctrl_tops_i(ctrl_tops_i), .ctrl_wst_i(ctrl_wst_i),
      .ctrl_wend_i(ctrl_wend_i), .m_rctrl_wr_i(m_rctrl_wr_i), .i_rctrl_wr_i(i_rctrl_wr_i),
      .rctrl_rst_i(rctrl_rst_i), .rctrl_nmi_i(rctrl_nmi_i), .int_reset_o(int_reset_o),
      .m_nmi_o(m_nmi_o), .m_irq_o(m_irq_o), .i_nmi_o(i_nmi_o), .i_irq_o(i_irq_o),
      .m_count_o(m_count_o), .i_count_o(i_count_o), .m_running_o(m_running_o),
      .i_running_o(i_running_o), .m_under_o(m_under_o), .i_under_o(i_under_o),
      .m_err_o(m_err_o), .i_err_o(i_err_o)
   );

   task final_report;
      begin
         if (fails == 0 && n_compared > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task cyc(input integer c);
      repeat (c) @(negedge clk_i);
   endtask

   task do_reset(input [31:0] boot);
      begin
         @(negedge clk_i);
         reset_i = 1'b1;
         boot_word_i = boot;
         cyc(3);
         reset_i = 1'b0;
         cyc(1);
      end
   endtask

   task wr_ctrl(input ind, input [2:0] cks, input [1:0] tops, input [1:0] wst, input [1:0] wend);
      begin
         {ctrl_cks_i, ctrl_tops_i, ctrl_wst_i, ctrl_wend_i} = {cks, tops, wst, wend};
         {m_ctrl_wr_i, i_ctrl_wr_i} = {!ind, ind};
         cyc(1);
         {m_ctrl_wr_i, i_ctrl_wr_i} = 2'h0;
         cyc(1);
      end
   endtask

   task wr_rctrl(input ind, input rst, input nmi);
      begin
         {rctrl_rst_i, rctrl_nmi_i} = {rst, nmi};
         {m_rctrl_wr_i, i_rctrl_wr_i} = {!ind, ind};
         cyc(1);
         {m_rctrl_wr_i, i_rctrl_wr_i} = 2'h0;
         cyc(1);
      end
   endtask

   task key(input [7:0] d0, input [7:0] d1);
      begin
         m_refr_wr_i = 1'b1;
         m_refr_data_i = d0;
         cyc(1);
         m_refr_data_i = d1;
         cyc(1);
         m_refr_wr_i = 1'b0;
      end
   endtask

   task i_kick;
      begin
         i_refr_wr_i = 1'b1;
         cyc(1);
         i_refr_wr_i = 1'b0;
      end
   endtask

   task wait_ev(input integer which, input integer lim);
      integer i;
      reg     hit;
      begin
         hit = 1'b0;
         for (i = 0; i < lim && !hit; i = i + 1) begin
            cyc(1);
            case (which)
               0: hit = (m_under_o === 1'b1);
               1: hit = (i_under_o === 1'b1);
               default: hit = (m_count_o <= 14'h02bc);
            endcase
         end
         if (!hit) begin
            fails = fails + 1;
            final_report;
         end
      end
   endtask

   // Cycles between two successive count steps
   task step_gap(input ind, output integer gap);
      reg [13:0] c;
      integer    i;
      begin
         c = ind ? i_count_o : m_count_o;
         for (i = 0; i < 20000 && c === (ind ? i_count_o : m_count_o); i = i + 1) cyc(1);
         c = ind ? i_count_o : m_count_o;
         gap = 0;
         for (i = 0; i < 20000 && c === (ind ? i_count_o : m_count_o); i = i + 1) begin
            cyc(1);
            gap = gap + 1;
         end
         if (i == 20000) begin
            fails = fails + 1;
            final_report;
         end
      end
   endtask

   initial begin
      // Rows: independent dog, divider code, clk_i cycles per step
      rows[0] = {1'b0, 3'h0, 14'h0004};
      rows[1] = {1'b0, 3'h1, 14'h0040};
      rows[2] = {1'b0, 3'h2, 14'h0080};
      rows[3] = {1'b0, 3'h3, 14'h0200};
      rows[4] = {1'b0, 3'h4, 14'h0800};
      rows[5] = {1'b0, 3'h5, 14'h2000};
      rows[6] = {1'b1, 3'h0, 14'h0004};
      rows[7] = {1'b1, 3'h1, 14'h0040};
      rows[8] = {1'b1, 3'h2, 14'h0080};
      rows[9] = {1'b1, 3'h3, 14'h0100};
      rows[10] = {1'b1, 3'h4, 14'h0200};
      rows[11] = {1'b1, 3'h5, 14'h0400};
      for (k = 0; k < 12; k = k + 1) begin
         do_reset(32'h0);
         wr_ctrl(rows[k][17], rows[k][16:14], 2'h0, 2'h0, 2'h3);
         if (rows[k][17]) i_kick;
         else key(8'h00, 8'hff);
         cyc(2);
         chk(rows[k][17] ? i_running_o : m_running_o, 1'b1);
         if (!rows[k][17]) chk(m_count_o, 14'h03ff);
         step_gap(rows[k][17], n);
         chk(n, rows[k][13:0]);
      end
      // Second control writes are dropped; main NMI, independent IRQ
      do_reset(32'h0);
      wr_ctrl(1'b0, 3'h0, 2'h0, 2'h0, 2'h3);
      wr_ctrl(1'b0, 3'h0, 2'h1, 2'h0, 2'h3);
      wr_ctrl(1'b1, 3'h0, 2'h0, 2'h0, 2'h3);
      wr_rctrl(1'b0, 1'b0, 1'b1);
      wr_rctrl(1'b0, 1'b1, 1'b0);
      wr_rctrl(1'b1, 1'b0, 1'b0);
      key(8'h00, 8'hff);
      i_kick;
      cyc(1);
      chk(m_count_o, 14'h03ff);
      cyc(20);
      all_stop_i = 1'b1;
      snap = m_count_o;
      snap2 = i_count_o;
      cyc(40);
      chk(m_count_o, snap);
      chk(i_count_o !== snap2, 1'b1);
      all_stop_i = 1'b0;
      wait_ev(0, 6000);
      wait_ev(1, 500);
      cyc(2);
      chk(seen, 5'h12);
      snap = m_count_o;
      cyc(10);
      chk({m_running_o, m_count_o}, {1'b0, snap});
      do_reset(32'h0a410000);
      chk({m_under_o, i_under_o, m_running_o, m_count_o}, 17'h00000);
      // Window 256..767: inside refresh reloads, outside is an error
      wr_ctrl(1'b0, 3'h0, 2'h0, 2'h1, 2'h2);
      wr_rctrl(1'b0, 1'b1, 1'b0);
      key(8'h00, 8'hff);
      i_kick;
      wait_ev(2, 2000);
      key(8'h00, 8'hff);
      cyc(2);
      chk({m_err_o, m_count_o}, {1'b0, 14'h03ff});
      key(8'h00, 8'hff);
      cyc(2);
      chk({i_err_o, m_err_o, m_running_o}, 3'h6);
      cyc(2);
      chk(seen, 5'h09);
      // Broken key sequence inside the window
      do_reset(32'h0);
      wr_ctrl(1'b0, 3'h0, 2'h0, 2'h1, 2'h2);
      key(8'h00, 8'hff);
      wait_ev(2, 2000);
      key(8'h5a, 8'hff);
      cyc(2);
      chk({m_err_o, m_running_o}, 2'h2);
      // Auto start: tops 1, reset action, control writes refused
      do_reset(32'h00000411);
      cyc(2);
      chk({m_running_o, m_count_o}, {1'b1, 14'h0fff});
      wr_ctrl(1'b0, 3'h5, 2'h0, 2'h0, 2'h3);
      key(8'h00, 8'hff);
      cyc(2);
      chk(m_count_o, 14'h0fff);
      step_gap(1'b0, n);
      chk(n, 4);
      wait_ev(0, 20000);
      cyc(3);
      chk(seen[2:0], 3'h1);
      final_report;
   end
endmodule
